// >>> rcf_regs.svh
/*
  Constants of the remote command response framer: frame layout, codes and limits.
  Assumes it is included by the package and the modules that build frames.
*/
// How it works
// - Each request of type 0x17 with a nonzero frame identifier gets a reply frame of type 0x97.
// - A request with frame identifier zero gets no reply at all.
// - Bytes 1 and 2 hold the count of bytes between length and checksum.
// - Byte 4 repeats the request's frame identifier for pairing.
// - Bytes 5 to 12 hold the responder's 64-bit address.
// - Bytes 13 and 14 hold a filler, normally 0xFFFE; host ignores it.
// - Bytes 15 and 16 hold the two ASCII command characters.
// - Byte 17 holds the status: 00 ok, 01, 02, 03, 04, 0c errors.
// - A parameter change reply stops after the status byte.
// - A query reply appends the current value after the status byte.
// - Last byte is 0xff minus the byte sum from offset 3 onward.
// - One request may produce several replies with the same identifier.
`ifndef RCF_REGS_SVH
`define RCF_REGS_SVH

`define RCF_DELIM        8'h7e
`define RCF_TYPE_REQ     8'h17
`define RCF_TYPE_RSP     8'h97
`define RCF_FILL_DFLT    16'hfffe
`define RCF_CSUM_BASE    8'hff
`define RCF_FIXED_LEN    16'h000f
`define RCF_ST_OK        8'h00
`define RCF_ST_ERR       8'h01
`define RCF_ST_BADCMD    8'h02
`define RCF_ST_BADPAR    8'h03
`define RCF_ST_TXFAIL    8'h04
`define RCF_ST_CRYPT     8'h0c
`define RCF_IDX_LEN_HI   5'h01
`define RCF_IDX_LEN_LO   5'h02
`define RCF_IDX_TYPE     5'h03
`define RCF_IDX_FID      5'h04
`define RCF_IDX_ADDR     5'h05
`define RCF_IDX_ADDR_END 5'h0c
`define RCF_IDX_FILL_HI  5'h0d
`define RCF_IDX_FILL_LO  5'h0e
`define RCF_IDX_CMD_HI   5'h0f
`define RCF_IDX_CMD_LO   5'h10
`define RCF_IDX_STATUS   5'h11
`define RCF_PAR_MAX      8'h14

`endif

// >>> rcf_pkg.sv
/*
  Types shared by the framer and its output buffer.
  Assumes the constants header is reachable by its bare name.
*/
`include "rcf_regs.svh"
package rcf_pkg;

  localparam int PAR_MAX = 20;

  // Descriptor of one reply, presented with a valid/ready handshake
  typedef struct packed {
    logic [7:0]           frame_id;
    logic [63:0]          src_addr;
    logic [15:0]          fill;
    logic [15:0]          cmd;
    logic [7:0]           status;
    logic [4:0]           par_len;
    logic [PAR_MAX*8-1:0] par;      // Byte 0 of the value in the top lane
  } rcf_rsp_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } rcf_byte_t;

  typedef enum logic [3:0] {
    RCF_IDLE = 4'b0001,
    RCF_HEAD = 4'b0010,
    RCF_PARM = 4'b0100,
    RCF_CSUM = 4'b1000
  } rcf_state_t;

endpackage

// >>> rcf_skid.sv
/*
  Two-entry buffer between the framer and the serial byte sink.
  Assumes a single clock with synchronous active-low reset.
*/
`timescale 1ns/1ps
module rcf_skid
  import rcf_pkg::*;
(
  input  wire logic               clk,      // Core clock
  input  wire logic               rst_n,    // Synchronous reset
  input  wire logic               in_vld,   // Producer byte valid
  input  wire rcf_pkg::rcf_byte_t in_data,  // Producer byte
  output logic                    in_rdy,   // Room for a byte
  output logic                    out_vld,  // Byte available
  output rcf_pkg::rcf_byte_t      out_data, // Oldest byte
  input  wire logic               out_rdy   // Consumer takes byte
);
  import rcf_pkg::*;

  typedef struct packed {
    rcf_byte_t  [1:0] mem;
    logic       [1:0] cnt;
  } rcf_skid_st_t;

  rcf_skid_st_t st_reg;
  rcf_skid_st_t st_next;

  always_comb
  begin
    logic pop;
    logic push;
    pop     = 1'b0;
    push    = 1'b0;
    st_next = st_reg;
    pop     = out_rdy && (st_reg.cnt != 2'h0);
    push    = in_vld && (st_reg.cnt != 2'h2);
    if (pop)
    begin
      st_next.mem[0] = st_reg.mem[1];
    end
    if (push)
    begin
      st_next.mem[st_reg.cnt - {1'b0, pop}] = in_data;
    end
    st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign in_rdy   = (st_reg.cnt != 2'h2);
  assign out_vld  = (st_reg.cnt != 2'h0);
  assign out_data = st_reg.mem[0];
endmodule

// >>> rcf_framer.sv
/*
  Remote command response framer: turns a finished remote command into the
  serial reply frame for the local host, byte by byte.
  Assumes the request decoder supplies one descriptor per reply and that the
  serial transmitter drains bytes with a ready handshake.
*/
`timescale 1ns/1ps
`include "rcf_regs.svh"
module rcf_framer
  import rcf_pkg::*;
#(
  parameter int PAR_BYTES = 20
)
(
  input  wire logic               CORE_CLK,   // 40 MHz core clock
  input  wire logic               RST_N,      // Synchronous reset, active low
  input  wire logic               RSP_VALID,  // Reply descriptor offered
  input  wire rcf_pkg::rcf_rsp_t  RSP_DESC,   // Reply contents
  output logic                    RSP_READY,  // Descriptor taken
  output logic                    TX_VALID,   // Byte valid toward host
  output logic [7:0]              TX_DATA,    // Frame byte
  output logic                    TX_LAST,    // Checksum byte marker
  input  wire logic               TX_READY,   // Host link takes byte
  output logic                    BUSY,       // Frame in progress
  output logic                    DROPPED     // Pulse: zero identifier suppressed
);
  import rcf_pkg::*;

  // The descriptor only has lanes for PAR_MAX value bytes
  if (PAR_BYTES < 1 || PAR_BYTES > PAR_MAX)
  begin : g_par_bytes_bad
    $error("PAR_BYTES out of range");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    rcf_state_t state;
    rcf_rsp_t   desc;
    logic [4:0] idx;
    logic [7:0] sum;
    logic       rdy;
    logic       busy;
    logic       drop;
    logic       tx_vld;
    rcf_byte_t  tx;
  } rcf_fr_st_t;

  rcf_fr_st_t st_reg;
  rcf_fr_st_t st_next;

  logic      buf_rdy;
  logic      emit;
  rcf_byte_t emit_byte;
  logic      out_vld;
  rcf_byte_t out_byte;

  function automatic logic [15:0] frame_len(input logic [4:0] plen);
    frame_len = `RCF_FIXED_LEN + {11'h000, plen};
  endfunction

  function automatic logic [7:0] head_byte(input rcf_rsp_t d, input logic [4:0] i);
    logic [15:0] len;
    logic [2:0]  a;
    len = frame_len(d.par_len);
    a   = 3'(i - `RCF_IDX_ADDR);
    case (i)
      `RCF_IDX_LEN_HI:  head_byte = len[15:8];
      `RCF_IDX_LEN_LO:  head_byte = len[7:0];
      `RCF_IDX_TYPE:    head_byte = `RCF_TYPE_RSP;
      `RCF_IDX_FID:     head_byte = d.frame_id;
      `RCF_IDX_FILL_HI: head_byte = d.fill[15:8];
      `RCF_IDX_FILL_LO: head_byte = d.fill[7:0];
      `RCF_IDX_CMD_HI:  head_byte = d.cmd[15:8];
      `RCF_IDX_CMD_LO:  head_byte = d.cmd[7:0];
      `RCF_IDX_STATUS:  head_byte = d.status;
      default:
      begin
        if (i >= `RCF_IDX_ADDR && i <= `RCF_IDX_ADDR_END)
        begin
          head_byte = d.src_addr[8*(7-a) +: 8];
        end
        else
        begin
          head_byte = `RCF_DELIM;
        end
      end
    endcase
  endfunction

  // ------------------------------------------------------------
  // Frame sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    logic [7:0] b;
    logic       adv;
    b         = 8'h00;
    adv       = 1'b0;
    st_next   = st_reg;
    emit      = 1'b0;
    emit_byte = '0;
    st_next.rdy  = 1'b0;
    st_next.drop = 1'b0;
    case (st_reg.state)
      RCF_IDLE:
      begin
        st_next.rdy = 1'b1;
        if (RSP_VALID && st_reg.rdy)
        begin
          st_next.rdy = 1'b0;
          if (RSP_DESC.frame_id == 8'h00)
          begin
            st_next.drop = 1'b1;
          end
          else
          begin
            st_next.desc  = RSP_DESC;
            if (RSP_DESC.par_len > 5'(PAR_BYTES))
            begin
              st_next.desc.par_len = 5'(PAR_BYTES);
            end
            st_next.idx   = '0;
            st_next.sum   = '0;
            st_next.busy  = 1'b1;
            st_next.state = RCF_HEAD;
          end
        end
      end
      RCF_HEAD:
      begin
        b         = head_byte(st_reg.desc, st_reg.idx);
        emit      = buf_rdy;
        emit_byte = '{data: b, last: 1'b0};
        if (buf_rdy)
        begin
          if (st_reg.idx >= `RCF_IDX_TYPE)
          begin
            st_next.sum = st_reg.sum + b;
          end
          st_next.idx = st_reg.idx + 5'h01;
          if (st_reg.idx == `RCF_IDX_STATUS)
          begin
            st_next.idx = '0;
            // Change replies end here, queries carry the value
            if (st_reg.desc.par_len == 5'h00)
            begin
              st_next.state = RCF_CSUM;
            end
            else
            begin
              st_next.state = RCF_PARM;
            end
          end
        end
      end
      RCF_PARM:
      begin
        b         = st_reg.desc.par[8*(PAR_MAX-1-32'(st_reg.idx)) +: 8];
        emit      = buf_rdy;
        emit_byte = '{data: b, last: 1'b0};
        adv       = buf_rdy;
        if (adv)
        begin
          st_next.sum = st_reg.sum + b;
          st_next.idx = st_reg.idx + 5'h01;
          if (st_reg.idx + 5'h01 == st_reg.desc.par_len)
          begin
            st_next.state = RCF_CSUM;
          end
        end
      end
      RCF_CSUM:
      begin
        emit      = buf_rdy;
        emit_byte = '{data: `RCF_CSUM_BASE - st_reg.sum, last: 1'b1};
        if (buf_rdy)
        begin
          st_next.busy  = 1'b0;
          st_next.state = RCF_IDLE;
        end
      end
      default:
      begin
        st_next.state = RCF_IDLE;
      end
    endcase
    st_next.tx_vld = out_vld;
    st_next.tx     = out_byte;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      st_reg       <= '0;
      st_reg.state <= RCF_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Output buffer
  // ------------------------------------------------------------
  // The output stage registers the buffer head, so a pop only happens
  // when the registered byte is consumed or absent.
  logic      skid_vld;
  rcf_byte_t skid_byte;
  logic      pop_ok;
  assign pop_ok = !st_reg.tx_vld || TX_READY;

  rcf_skid u_skid (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .in_vld   (emit),
    .in_data  (emit_byte),
    .in_rdy   (buf_rdy),
    .out_vld  (skid_vld),
    .out_data (skid_byte),
    .out_rdy  (pop_ok)
  );

  always_comb
  begin
    out_vld  = st_reg.tx_vld && !TX_READY;
    out_byte = st_reg.tx;
    if (pop_ok)
    begin
      out_vld  = skid_vld;
      out_byte = skid_byte;
    end
  end

  assign RSP_READY = st_reg.rdy;
  assign TX_VALID  = st_reg.tx_vld;
  assign TX_DATA   = st_reg.tx.data;
  assign TX_LAST   = st_reg.tx.last;
  assign BUSY      = st_reg.busy;
  assign DROPPED   = st_reg.drop;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_take_zero;
    RSP_VALID && RSP_READY && RSP_DESC.frame_id == 8'h00;
  endsequence

  property p_zero_drop;
    @(posedge CORE_CLK) disable iff (!RST_N)
      s_take_zero |=> DROPPED && !BUSY;
  endproperty
  a_zero_drop: assert property (p_zero_drop) else $error("zero id not dropped");

  property p_start_delim;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (st_reg.state == RCF_HEAD && st_reg.idx == 5'h00 && buf_rdy)
        |-> emit_byte.data == `RCF_DELIM;
  endproperty
  a_start_delim: assert property (p_start_delim) else $error("bad delimiter");

  property p_type;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (st_reg.state == RCF_HEAD && st_reg.idx == `RCF_IDX_TYPE)
        |-> emit_byte.data == `RCF_TYPE_RSP;
  endproperty
  a_type: assert property (p_type) else $error("bad frame type");

  property p_fid;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (st_reg.state == RCF_HEAD && st_reg.idx == `RCF_IDX_FID)
        |-> emit_byte.data == st_reg.desc.frame_id && emit_byte.data != 8'h00;
  endproperty
  a_fid: assert property (p_fid) else $error("bad frame id");

  property p_len;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (st_reg.state == RCF_HEAD && st_reg.idx == `RCF_IDX_LEN_LO)
        |-> emit_byte.data == 8'(`RCF_FIXED_LEN + 16'(st_reg.desc.par_len));
  endproperty
  a_len: assert property (p_len) else $error("bad length");

  property p_no_param;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (st_reg.state == RCF_HEAD && st_reg.idx == `RCF_IDX_STATUS && buf_rdy
        && st_reg.desc.par_len == 5'h00) |=> st_reg.state == RCF_CSUM;
  endproperty
  a_no_param: assert property (p_no_param) else $error("change reply has value");

  property p_csum_last;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (st_reg.state == RCF_CSUM && buf_rdy)
        |-> emit_byte.last && emit_byte.data + st_reg.sum == 8'hff;
  endproperty
  a_csum_last: assert property (p_csum_last) else $error("bad checksum");

  property p_hold;
    @(posedge CORE_CLK) disable iff (!RST_N)
      TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST);
  endproperty
  a_hold: assert property (p_hold) else $error("byte changed while stalled");

  property p_param_end;
    @(posedge CORE_CLK) disable iff (!RST_N)
      $rose(st_reg.state == RCF_PARM) |-> ##[1:200] st_reg.state == RCF_CSUM;
  endproperty
  a_param_end: assert property (p_param_end) else $error("value never ends");
endmodule

// >>> rcf_host_model.sv
/*
  Host side of the serial reply link: takes framer bytes, keeps them for the bench
  and checks each frame's checksum.
  Assumes the bench drives stall away from the rising clock edge.
*/
`timescale 1ns/1ps
module rcf_host_model
(
  input  wire logic       clk,      // Core clock
  input  wire logic       rst_n,    // Synchronous reset
  input  wire logic       tx_valid, // Byte offered
  input  wire logic [7:0] tx_data,  // Frame byte
  input  wire logic       tx_last,  // Checksum marker
  input  wire logic       stall,    // Bench asks for back-pressure
  output logic            tx_ready  // Byte accepted
);
  logic [8:0] rx_q[$];
  int         idx = 0;
  int         n_bad = 0;
  logic [7:0] sum = 8'h00;

  assign tx_ready = ~stall;

  // Reserved bytes are never inspected here
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      idx = 0;
      sum = 8'h00;
    end
    else if (tx_valid && tx_ready)
    begin
      rx_q.push_back({tx_last, tx_data});
      if (idx >= 3)
        sum = sum + tx_data;
      idx++;
      if (tx_last)
      begin
        if (sum !== 8'hff)
          n_bad++;
        idx = 0;
        sum = 8'h00;
      end
    end
  end
endmodule

// >>> tb_remote_cmd_response_framer.sv
/*
  Self-checking bench: random reply descriptors, expected frames built from integers
  and queues, compared byte by byte with what the host model received.
  Assumes the framer and its package are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_remote_cmd_response_framer;
  import rcf_pkg::*;
  logic       CORE_CLK = 1'b0;
  logic       RST_N = 1'b0;
  logic       RSP_VALID = 1'b0;
  rcf_rsp_t   RSP_DESC = '0;
  logic       RSP_READY;
  logic       TX_VALID;
  logic [7:0] TX_DATA;
  logic       TX_LAST;
  logic       TX_READY;
  logic       BUSY;
  logic       DROPPED;
  logic       stall = 1'b0;
  logic       stall_on = 1'b0;
  int         seed = 32'hff3d;
  int         n_mismatch = 0;
  int         comparisons = 0;
  int         n_drop = 0;
  int         exp_drop = 0;
  int         cyc = 0;
  logic [8:0] exp_q[$];
  logic [7:0] codes[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0c};
  int         qlen[5] = '{1, 20, 2, 7, 19};

  rcf_framer u_rcf_framer (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .RSP_VALID(RSP_VALID),
    .RSP_DESC(RSP_DESC), .RSP_READY(RSP_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
    .TX_LAST(TX_LAST), .TX_READY(TX_READY), .BUSY(BUSY), .DROPPED(DROPPED));
  rcf_host_model u_rcf_host_model (.clk(CORE_CLK), .rst_n(RST_N), .tx_valid(TX_VALID),
    .tx_data(TX_DATA), .tx_last(TX_LAST), .stall(stall), .tx_ready(TX_READY));

  always #12.5 CORE_CLK = ~CORE_CLK;

  always @(negedge CORE_CLK)
    stall <= stall_on && (($random(seed) & 3) == 0);

  // Outputs are settled at the falling edge
  always @(negedge CORE_CLK)
  begin
    if (RST_N && DROPPED === 1'b1)
      n_drop++;
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // Reference model and bus tasks
  // ------------------------------------------------------------
  function automatic rcf_rsp_t mk(logic [7:0] id, logic [7:0] st, int plen);
    rcf_rsp_t d;
    d.frame_id = id;
    d.src_addr = {$random(seed), $random(seed)};
    d.fill = 16'($random(seed));
    d.cmd = {8'h41 + 8'($random(seed) & 15), 8'h41 + 8'($random(seed) & 15)};
    d.status = st;
    d.par_len = 5'(plen);
    d.par = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    return d;
  endfunction

  task automatic send(rcf_rsp_t d);
    int k;
    logic [7:0] b[$];
    int sum;
    k = 0;
    sum = 0;
    @(negedge CORE_CLK);
    RSP_DESC = d;
    RSP_VALID = 1'b1;
    // Ready seen high at a falling edge means the next rising edge takes
    while (RSP_READY !== 1'b1 && k < 300)
    begin
      @(negedge CORE_CLK);
      k++;
    end
    @(negedge CORE_CLK);
    RSP_VALID = 1'b0;
    if (k >= 300)
      n_mismatch++;
    `CHK(BUSY, (d.frame_id != 8'h00))
    `CHK(DROPPED, (d.frame_id == 8'h00))
    if (d.frame_id == 8'h00)
      exp_drop++;
    else
    begin
      b = {8'h97, d.frame_id};
      for (int i = 7; i >= 0; i--)
        b.push_back(d.src_addr[8*i +: 8]);
      b = {b, d.fill[15:8], d.fill[7:0], d.cmd[15:8], d.cmd[7:0], d.status};
      for (int i = 0; i < int'(d.par_len); i++)
        b.push_back(d.par[PAR_MAX*8-1-8*i -: 8]);
      exp_q.push_back({1'b0, 8'h7e});
      exp_q.push_back({1'b0, 8'((b.size() >> 8))});
      exp_q.push_back({1'b0, 8'(b.size())});
      foreach (b[i])
      begin
        exp_q.push_back({1'b0, b[i]});
        sum += b[i];
      end
      exp_q.push_back({1'b1, 8'hff - 8'(sum)});
    end
  endtask

  task automatic check_rx(string name);
    int k;
    logic [8:0] got_b;
    logic [8:0] exp_b;
    k = 0;
    while ((u_rcf_host_model.rx_q.size() < exp_q.size() || BUSY !== 1'b0) && k < 1000)
    begin
      @(negedge CORE_CLK);
      k++;
    end
    repeat (4) @(negedge CORE_CLK);
    `CHK(BUSY, 1'b0)
    `CHK(u_rcf_host_model.rx_q.size(), exp_q.size())
    while (exp_q.size() > 0 && u_rcf_host_model.rx_q.size() > 0)
    begin
      got_b = u_rcf_host_model.rx_q.pop_front();
      exp_b = exp_q.pop_front();
      `CHK(got_b, exp_b)
    end
    exp_q.delete();
    u_rcf_host_model.rx_q.delete();
    `CHK(n_drop, exp_drop)
    `CHK(u_rcf_host_model.n_bad, 0)
    $display("Test %s done, mismatches so far %0d", name, n_mismatch);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (6) @(negedge CORE_CLK);
    RST_N = 1'b1;
    // Every status code on a change reply, frames queued back to back
    foreach (codes[i])
      send(mk(8'(i + 1), codes[i], 0));
    check_rx("status");
    // Query replies with value lengths at the edges, host stalling
    stall_on = 1'b1;
    foreach (qlen[i])
      send(mk(8'($random(seed)) | 8'h01, 8'h00, qlen[i]));
    send(mk(8'($random(seed)) | 8'h01, 8'h00, 1 + (($random(seed) & 32'h7fff) % 20)));
    check_rx("query");
    // Two zero identifiers squeezed between two replies
    send(mk(8'h55, 8'h00, 0));
    send(mk(8'h00, 8'h01, 3));
    send(mk(8'h00, 8'h00, 0));
    send(mk(8'haa, 8'h02, 2));
    check_rx("drop");
    // Several replies to one discovery request share an identifier
    repeat (3)
      send(mk(8'h33, 8'h00, 10));
    check_rx("repeat");
    close_out();
  end
endmodule
